//--- shared/cst_alu_if.sv
// Purpose: carries an operation and its flag results between modules
// Assumes: combinational path only
// Notes: upd_* say which flags the operation affects
`timescale 1ns/1ps
interface cst_alu_if;
  import cst_pkg::*;
  cst_op_type op;
  logic [7:0] acc;
  logic [7:0] src;
  logic [7:0] bitsel;
  logic carry_in;
  logic [7:0] res;
  logic z;
  logic dc;
  logic c;
  logic upd_z;
  logic upd_dc;
  logic upd_c;
  modport core (output op, acc, src, bitsel, carry_in,
    input res, z, dc, c, upd_z, upd_dc, upd_c);
  modport alu (input op, acc, src, bitsel, carry_in,
    output res, z, dc, c, upd_z, upd_dc, upd_c);
endinterface

//--- shared/cst_consts.svh
// Purpose: offsets, field positions and reset values of the status block
// Assumes: included by bare name from design files
// Notes: definitions only
`ifndef CST_CONSTS_SVH
`define CST_CONSTS_SVH
`define CST_OFS_STATUS_B0 8'h03
`define CST_OFS_STATUS_B1 8'h83
`define CST_OFS_CAUSE 8'h8E
`define CST_APB_STATUS 12'h000
`define CST_APB_CAUSE 12'h004
`define CST_APB_OP 12'h008
`define CST_APB_ACC 12'h00C
`define CST_APB_DATA 12'h010
`define CST_APB_EVT 12'h014
`define CST_APB_BANK 12'h018
`define CST_BIT_C 0
`define CST_BIT_DC 1
`define CST_BIT_Z 2
`define CST_BIT_PD 3
`define CST_BIT_TO 4
`define CST_BIT_BSL 5
`define CST_BIT_BSH 6
`define CST_BIT_IRP 7
`define CST_BIT_BOR 0
`define CST_BIT_POR 1
`define CST_STATUS_POR 8'h18
`define CST_BANK_SPAN 9'h080
`define CST_EVT_WDTO 0
`define CST_EVT_WCLR 1
`define CST_EVT_SLEEP 2
`define CST_EVT_PORST 3
`define CST_EVT_BOR 4
`endif

//--- shared/cst_pkg.sv
// Purpose: types shared by the status block files
// Assumes: nothing
// Notes: operation codes for the instruction port
package cst_pkg;
  typedef enum logic [3:0] {
    CST_OP_MOVE,
    CST_OP_CLEAR,
    CST_OP_ADD,
    CST_OP_SUB,
    CST_OP_AND,
    CST_OP_IOR,
    CST_OP_XOR,
    CST_OP_RRF,
    CST_OP_RLF,
    CST_OP_BCF,
    CST_OP_BSF,
    CST_OP_SWAP,
    CST_OP_INC,
    CST_OP_DEC,
    CST_OP_COMF
  } cst_op_type;
endpackage

//--- verification/cst_status_top_chk.sv
// Purpose: port-level assertions for the status block
// Assumes: single clock, synchronous active-high reset
// Notes: APB answer lands one cycle after the access edge
`timescale 1ns/1ps
module cst_status_chk #(
  parameter int ADDR_W = 12
)
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [31:0] prdata_o,
  input wire logic [7:0] status_o,
  input wire logic [8:0] direct_addr_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // access edge; strobe lane 0 gates every write
  wire logic tk = psel_i && penable_i && !pready_o;
  wire logic wr = tk && pwrite_i && pstrb_i[0];
  wire logic st_w = wr && paddr_i == 12'h000;
  wire logic ev_w = wr && paddr_i == 12'h014;
  // op issued with the status register as destination
  wire logic op_w = wr && paddr_i == 12'h008;
  wire logic op_st = op_w && pwdata_i[15] &&
    (pwdata_i[11:4] == 8'h03 || pwdata_i[11:4] == 8'h83);
  property p_rdy;
    tk |=> pready_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no answer");
  property p_one;
    pready_o |=> !pready_o;
  endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_unm;
    tk && paddr_i > 12'h018 |=> pslverr_o && prdata_o == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
  property p_hi0;
    pready_o |-> prdata_o[31:16] == 16'h0;
  endproperty
  a_hi0: assert property (p_hi0) else $error("upper bits");
  property p_keep;
    st_w |=> $stable(status_o[4:3]);
  endproperty
  a_keep: assert property (p_keep) else $error("flags written");
  property p_load;
    st_w |=> {status_o[7:5], status_o[2:0]} ==
      $past({pwdata_i[7:5], pwdata_i[2:0]});
  endproperty
  a_load: assert property (p_load) else $error("open bits");
  property p_sleep;
    ev_w && pwdata_i[4:0] == 5'h04 |=> status_o[4:3] == 2'b10;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep");
  property p_wdt;
    ev_w && pwdata_i[4:0] == 5'h01 |=> status_o[7:4] == 4'h0;
  endproperty
  a_wdt: assert property (p_wdt) else $error("expiry");
  property p_wclr;
    ev_w && pwdata_i[4:0] == 5'h02 |=> status_o[4:3] == 2'b11;
  endproperty
  a_wclr: assert property (p_wclr) else $error("wd clear");
  // address may trail the bank bits by one cycle
  property p_bank;
    $stable(status_o[6:5]) |-> direct_addr_o[8:7] == status_o[6:5];
  endproperty
  a_bank: assert property (p_bank) else $error("bank");
  property p_por;
    $fell(sys_rst_i) |-> status_o == 8'h18;
  endproperty
  a_por: assert property (p_por) else $error("power-up");
  property p_clr;
    op_st && pwdata_i[3:0] == 4'h1 |=> status_o[7:5] == 3'h0 &&
      status_o[2] && $stable(status_o[4:3]) && $stable(status_o[1:0]);
  endproperty
  a_clr: assert property (p_clr) else $error("clear on status");
  property p_lock;
    op_st && pwdata_i[3:0] inside {4'h4, 4'h5, 4'h6, 4'hC, 4'hD, 4'hE}
      |=> $stable(status_o[1:0]);
  endproperty
  a_lock: assert property (p_lock) else $error("carry written");
  c_sleep: cover property (ev_w && pwdata_i[4:0] == 5'h04);
  c_err: cover property (pslverr_o);
  c_bank3: cover property (direct_addr_o[8:7] == 2'h3);
endmodule
bind cst_status_top cst_status_chk #(.ADDR_W(ADDR_W)) u_cst_status_chk (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .prdata_o(prdata_o), .status_o(status_o),
  .direct_addr_o(direct_addr_o));

//--- verification/cst_status_top_tb.sv
// Purpose: self-checking bench for the status block
// Assumes: APB slave answers on its own; bench only waits
// Notes: brown-out flag taken as 0 at power-up
`timescale 1ns/1ps
module cst_status_top_tb
  import cst_pkg::*;
;
  logic clk, rst, psel, pen, pwr, fuse, rdy, err, e;
  logic [11:0] paddr;
  logic [31:0] pwd, prd, q;
  logic [3:0] pstrb;
  logic [7:0] st, res;
  logic [8:0] dadr;
  int n_fail = 0;
  int total_checks = 0;

  cst_status_top u_cst_status_top (.ref_clk_i(clk), .sys_rst_i(rst),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwd), .pstrb_i(pstrb), .brownout_enable_fuse_i(fuse),
    .pready_o(rdy), .pslverr_o(err), .prdata_o(prd), .status_o(st),
    .result_o(res), .direct_addr_o(dadr));

  // core clock
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  task end_of_test;
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(string nm, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // one transfer; an idle edge after release keeps strobes apart
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    q = prd;
    e = err;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask

  // result always goes back to the file
  task automatic op(cst_op_type c, logic [7:0] f);
    apb(1, 12'h008, {16'h0, 4'h8, f, c});
  endtask

  // bit-numbered op with the status register as destination
  task automatic bop(cst_op_type c, logic [2:0] b);
    apb(1, 12'h008, {16'h0, 1'b1, b, 8'h03, c});
  endtask

  task automatic alu(logic [7:0] a, logic [7:0] d, cst_op_type c,
      logic [2:0] f);
    apb(1, 12'h00C, a);
    apb(1, 12'h010, d);
    op(c, 8'h10);
    chk("flags", f, st[2:0]);
  endtask

  task t_reset;
    chk("status", 8'h18, st);
    apb(0, 12'h004, 0);
    chk("cause", 0, q);
    apb(0, 12'h01C, 0);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
  endtask

  task t_write;
    apb(1, 12'h000, 0);
    chk("status", 8'h18, st);
    apb(1, 12'h00C, 8'h27);
    op(CST_OP_MOVE, 8'h03);
    chk("status", 8'h3F, st);
    op(CST_OP_CLEAR, 8'h83);
    chk("status", 8'h1F, st);
  endtask

  task t_bank;
    apb(1, 12'h018, 8'h05);
    for (int b = 0; b < 4; b++) begin
      apb(1, 12'h000, b << 5);
      @(posedge clk);
      chk("direct addr", {b[1:0], 7'h05}, dadr);
    end
    apb(1, 12'h000, 0); // bank select bits back to zero
  endtask

  task t_alu;
    alu(8'h8F, 8'h71, CST_OP_ADD, 3'h7);
    chk("result", 8'h00, res);
    alu(8'h01, 8'h01, CST_OP_ADD, 3'h0);
    alu(8'h5A, 8'h5A, CST_OP_SUB, 3'h7);
    alu(8'h00, 8'h80, CST_OP_RRF, 3'h6);
    alu(8'h00, 8'h80, CST_OP_RLF, 3'h7);
    alu(8'h00, 8'h01, CST_OP_RLF, 3'h6);
    alu(8'h01, 8'h00, CST_OP_IOR, 3'h2);
    apb(1, 12'h000, 0);
    apb(1, 12'h00C, 8'hE8);
    op(CST_OP_ADD, 8'h03);
    chk("status", 8'h1F, st);
  endtask

  task t_event;
    apb(1, 12'h000, 8'h20);
    apb(1, 12'h014, 8'h04);
    chk("status", 8'h30, st);
    apb(1, 12'h014, 8'h01);
    chk("status", 8'h00, st);
    apb(1, 12'h014, 8'h02);
    chk("status", 8'h18, st);
  endtask

  // with the fuse off a brown-out leaves the flag alone
  task t_cause;
    apb(1, 12'h004, 8'h03);
    fuse <= 0;
    apb(1, 12'h014, 8'h10);
    apb(0, 12'h004, 0);
    chk("cause", 8'h03, q);
    fuse <= 1;
    apb(1, 12'h014, 8'h10);
    apb(0, 12'h004, 0);
    chk("cause", 8'h02, q);
    apb(1, 12'h014, 8'h08);
    apb(0, 12'h004, 0);
    chk("power-on flag", 0, q[1]);
  endtask

  // status changed by bit ops; logic ops move only the zero flag
  task t_bitop;
    apb(1, 12'h000, 0);
    bop(CST_OP_BSF, 3'h0);
    chk("status", 8'h19, st);
    bop(CST_OP_BSF, 3'h5);
    chk("status", 8'h39, st);
    bop(CST_OP_BCF, 3'h5);
    chk("status", 8'h19, st);
    op(CST_OP_INC, 8'h03);
    chk("status", 8'h19, st);
    alu(8'h0F, 8'hF0, CST_OP_AND, 3'h5);
    alu(8'h00, 8'h00, CST_OP_COMF, 3'h1);
    alu(8'h00, 8'h01, CST_OP_DEC, 3'h5);
    alu(8'hFF, 8'h0F, CST_OP_XOR, 3'h1);
    chk("result", 8'hF0, res);
    alu(8'h00, 8'h3C, CST_OP_SWAP, 3'h1);
    chk("result", 8'hC3, res);
  endtask

  // reset again in mid-run: power-up values come back
  task t_rst2;
    apb(1, 12'h000, 8'h27);
    apb(1, 12'h004, 8'h02);
    rst <= 1;
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk("status", 8'h18, st);
    chk("direct addr", 0, dadr);
    apb(0, 12'h004, 0);
    chk("cause", 0, q);
  endtask

  // reset, scenarios, verdict
  initial begin
    rst = 1;
    psel = 0;
    pen = 0;
    pwr = 0;
    paddr = 0;
    pwd = 0;
    pstrb = 4'hF;
    fuse = 1;
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_reset;
    t_write;
    t_bank;
    t_alu;
    t_event;
    t_cause;
    t_bitop;
    t_rst2;
    end_of_test;
  end

  // watchdog, well past the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_of_test;
  end
endmodule

//--- verilog/cst_alu.sv
// Purpose: operation result and zero, nibble carry, carry flags
// Assumes: purely combinational
// Notes: subtraction is an add of the two's complement
`timescale 1ns/1ps
module cst_alu
  import cst_pkg::*;
(
  cst_alu_if.alu a
);
  logic [4:0] lo_sum;
  logic [8:0] full_sum;
  logic [7:0] addend;
  logic add_like;
  logic carry_add;

  assign addend = (a.op == CST_OP_SUB) ? (~a.src) : a.src;
  assign carry_add = (a.op == CST_OP_SUB);
  assign add_like = (a.op == CST_OP_ADD) || (a.op == CST_OP_SUB);
  assign lo_sum = {1'b0, a.acc[3:0]} + {1'b0, addend[3:0]}
    + {4'h0, carry_add};
  assign full_sum = {1'b0, a.acc} + {1'b0, addend} + {8'h00, carry_add};

  // result selection per operation
  always_comb begin
    a.res = a.src;
    unique case (a.op)
      CST_OP_MOVE: a.res = a.acc;
      CST_OP_CLEAR: a.res = 8'h00;
      CST_OP_ADD, CST_OP_SUB: a.res = full_sum[7:0];
      CST_OP_AND: a.res = a.acc & a.src;
      CST_OP_IOR: a.res = a.acc | a.src;
      CST_OP_XOR: a.res = a.acc ^ a.src;
      CST_OP_RRF: a.res = {a.carry_in, a.src[7:1]};
      CST_OP_RLF: a.res = {a.src[6:0], a.carry_in};
      CST_OP_BCF: a.res = a.src & ~a.bitsel;
      CST_OP_BSF: a.res = a.src | a.bitsel;
      CST_OP_SWAP: a.res = {a.src[3:0], a.src[7:4]};
      CST_OP_INC: a.res = a.src + 8'h01;
      CST_OP_DEC: a.res = a.src - 8'h01;
      CST_OP_COMF: a.res = ~a.src;
    endcase
  end

  assign a.z = (a.res == 8'h00);
  assign a.dc = lo_sum[4];
  assign a.c = (a.op == CST_OP_RRF) ? a.src[0] :
    (a.op == CST_OP_RLF) ? a.src[7] : full_sum[8];
  // move, bit ops and swap leave every flag alone
  assign a.upd_z = !(a.op inside {CST_OP_MOVE, CST_OP_BCF, CST_OP_BSF,
    CST_OP_SWAP, CST_OP_RRF, CST_OP_RLF});
  assign a.upd_dc = add_like;
  assign a.upd_c = add_like || (a.op == CST_OP_RRF) || (a.op == CST_OP_RLF);
endmodule

//--- verilog/cst_bank_dec.sv
// Purpose: bank select to direct data address
// Assumes: combinational
// Notes: 128 bytes per bank
`timescale 1ns/1ps
`include "cst_consts.svh"
module cst_bank_dec
(
  input wire logic [1:0] bank_i,
  input wire logic [6:0] offs_i,
  output logic [8:0] addr_o
);
  logic [8:0] base;
  assign base = (`CST_BANK_SPAN) * {7'h00, bank_i};
  assign addr_o = base + {2'h0, offs_i};
endmodule

//--- verilog/cst_status_top.sv
// Purpose: processor status and reset-cause registers behind APB
// Assumes: one clock, synchronous active-high reset; the reset input
//   stands for the power-on reset, other resets arrive as event pulses
// Notes: an instruction is issued by writing the op register
// Functional notes
// - flag-affecting op on status: flag bits take the result, not data
// - time-out and power-down ignore instruction writes
// - clear on status zeros bits 7:5, keeps reset flags, sets zero
// - bank bits 6:5 pick a 128-byte direct-addressing bank
// - time-out set on power-up, watchdog clear, sleep; cleared by expiry
// - zero flag set on zero result, cleared on nonzero
// - nibble carry is carry out of bit 3, borrow inverted
// - carry is carry out of bit 7, one means no borrow
// - subtraction adds two's complement of second operand
// - rotates load carry with the bit shifted out
// - status reachable at data addresses 03h and 83h
// - any op may target status; open bits take the value
// - reset-cause register tells apart power-on, pin, watchdog, brown-out
// - brown-out flag unknown at power-up, set by software
// - brown-out flag meaningless with brown-out disabled
// - pin, brown-out, watchdog resets are non-power-up resets
// - unimplemented locations and bits read zero
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "cst_consts.svh"
module cst_status_top
  import cst_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic brownout_enable_fuse_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  output logic [7:0] status_o,
  output logic [7:0] result_o,
  output logic [8:0] direct_addr_o
);
  // refuse a bus too narrow to reach the whole register map
  if (ADDR_W < 5) begin : g_addr_chk
    $error("cst_status_top: ADDR_W too small");
  end

  cst_alu_if alu_bus ();
  logic [7:0] status_q, status_d;
  logic [1:0] cause_q, cause_d;
  logic [7:0] acc_q, data_q, bank_q, result_q;
  logic [15:0] op_q;
  logic [8:0] daddr_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [8:0] daddr_w;

  // apb decode; access phase takes one wait state
  wire acc_phase = psel_i && penable_i && !pready_q;
  wire wr_en = acc_phase && pwrite_i && pstrb_i[0];
  wire [11:0] a12 = 12'(paddr_i);
  wire hit_stat = (a12 == `CST_APB_STATUS);
  wire hit_cause = (a12 == `CST_APB_CAUSE);
  wire hit_op = (a12 == `CST_APB_OP);
  wire hit_acc = (a12 == `CST_APB_ACC);
  wire hit_data = (a12 == `CST_APB_DATA);
  wire hit_evt = (a12 == `CST_APB_EVT);
  wire hit_bank = (a12 == `CST_APB_BANK);
  wire mapped = hit_stat | hit_cause | hit_op | hit_acc | hit_data |
    hit_evt | hit_bank;
  // op word: [3:0] op code, [11:4] file address, [14:12] bit, [15] dest
  wire issue = wr_en && hit_op;
  wire [7:0] f_addr = pwdata_i[11:4];
  wire to_file = pwdata_i[15];
  // both bank images map the same register
  wire tgt_stat = to_file && ((f_addr == `CST_OFS_STATUS_B0) ||
    (f_addr == `CST_OFS_STATUS_B1));
  wire tgt_cause = to_file && (f_addr == `CST_OFS_CAUSE);
  wire [3:0] op_raw = pwdata_i[3:0];
  wire op_ok = (op_raw <= 4'(CST_OP_COMF));
  wire [7:0] src_val = tgt_stat ? status_q :
    tgt_cause ? {6'h00, cause_q} : data_q;
  // event strobes written by the reset and power logic
  wire ev_wdto = wr_en && hit_evt && pwdata_i[`CST_EVT_WDTO];
  wire ev_wclr = (wr_en && hit_evt && pwdata_i[`CST_EVT_WCLR]);
  wire ev_sleep = (wr_en && hit_evt && pwdata_i[`CST_EVT_SLEEP]);
  wire ev_por = wr_en && hit_evt && pwdata_i[`CST_EVT_PORST];
  wire ev_bor = wr_en && hit_evt && pwdata_i[`CST_EVT_BOR];

  // operation presented to the alu
  assign alu_bus.op = op_ok ? cst_op_type'(op_raw) : CST_OP_MOVE;
  assign alu_bus.acc = acc_q;
  assign alu_bus.src = src_val;
  assign alu_bus.bitsel = 8'h01 << pwdata_i[14:12];
  assign alu_bus.carry_in = status_q[`CST_BIT_C];
  // set when the op updates any of zero, nibble carry or carry
  wire flag_op = alu_bus.upd_z | alu_bus.upd_dc | alu_bus.upd_c;

  cst_alu u_alu (
    .a(alu_bus)
  );

  cst_bank_dec u_bank (
    .bank_i(status_q[`CST_BIT_BSH:`CST_BIT_BSL]),
    .offs_i(bank_q[6:0]),
    .addr_o(daddr_w)
  );

  // status next value: data write, then flags, then reset logic
  always_comb begin
    status_d = status_q;
    if (issue && op_ok) begin
      // open bits take the written value
      if (tgt_stat) begin
        status_d[7:5] = alu_bus.res[7:5];
        // a flag-affecting op locks all three flag bits, so a
        // clear keeps both carries and only the zero flag moves
        if (!flag_op)
          status_d[2:0] = alu_bus.res[2:0];
        // time-out and power-down never written here
      end
      // clear of status sets zero via alu flag path
      if (alu_bus.upd_z) status_d[`CST_BIT_Z] = alu_bus.z;
      if (alu_bus.upd_dc) status_d[`CST_BIT_DC] = alu_bus.dc;
      if (alu_bus.upd_c) status_d[`CST_BIT_C] = alu_bus.c;
    end
    // direct software load of status is also a status-destined write
    if (wr_en && hit_stat) begin
      status_d[7:5] = pwdata_i[7:5];
      status_d[2:0] = pwdata_i[2:0];
    end
    if (ev_wclr || ev_sleep) status_d[`CST_BIT_TO] = 1'b1;
    if (ev_wdto) status_d[`CST_BIT_TO] = 1'b0;
    if (ev_wclr) status_d[`CST_BIT_PD] = 1'b1;
    if (ev_sleep) status_d[`CST_BIT_PD] = 1'b0;
    // non-power-up resets clear bits 7:5, IRP and both bank bits
    if (ev_wdto || ev_bor) status_d[7:5] = 3'h0;
  end

  // reset-cause next value
  always_comb begin
    cause_d = cause_q;
    // software sets flags by write or instruction
    if (wr_en && hit_cause) cause_d = cause_q | pwdata_i[1:0];
    if (issue && op_ok && tgt_cause) cause_d = alu_bus.res[1:0];
    // power-on and brown-out causes clear their flag
    if (ev_por) cause_d[`CST_BIT_POR] = 1'b0;
    // flag meaningless with the fuse off, left as is
    if (ev_bor && brownout_enable_fuse_i) cause_d[`CST_BIT_BOR] = 1'b0;
  end

  // unmapped and unimplemented bits read zero
  wire [7:0] rd_byte = hit_stat ? status_q :
    hit_cause ? {6'h00, cause_q} :
    hit_acc ? acc_q :
    hit_data ? data_q :
    hit_bank ? bank_q : 8'h00;
  wire [31:0] rd_word = hit_op ? {16'h0000, op_q} : {24'h000000, rd_byte};

  // architectural registers; power-on values under reset
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      status_q <= `CST_STATUS_POR;
      cause_q <= 2'h0;
    end else begin
      status_q <= status_d;
      cause_q <= cause_d;
    end
  end

  // operand, result and bank offset registers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      acc_q <= 8'h00;
      data_q <= 8'h00;
      bank_q <= 8'h00;
      op_q <= 16'h0000;
      result_q <= 8'h00;
    end else begin
      if (wr_en && hit_acc) acc_q <= pwdata_i[7:0];
      if (wr_en && hit_bank) bank_q <= {1'b0, pwdata_i[6:0]};
      if (wr_en && hit_data) data_q <= pwdata_i[7:0];
      else if (issue && op_ok && to_file && !tgt_stat && !tgt_cause)
        data_q <= alu_bus.res;
      if (issue && op_ok && !to_file) acc_q <= alu_bus.res;
      if (issue) op_q <= pwdata_i[15:0];
      if (issue && op_ok) result_q <= alu_bus.res;
    end
  end

  // apb answer one cycle into access phase; reads registered
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      daddr_q <= 9'h000;
    end else begin
      pready_q <= acc_phase;
      pslverr_q <= acc_phase && (!mapped ||
        (pwrite_i && hit_op && !op_ok));
      prdata_q <= (acc_phase && !pwrite_i) ? rd_word : 32'h0000_0000;
      daddr_q <= daddr_w;
    end
  end

  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign prdata_o = prdata_q;
  assign status_o = status_q;
  assign result_o = result_q;
  assign direct_addr_o = daddr_q;
endmodule
